// ===== src/coef_reg.v
`timescale 1ns/10ps
module coef_reg
#(
	parameter WIDTH = 16
)
(
	// clock and reset
	input  wire             clock,
	input  wire             reset_n,
	// write port
	input  wire             write_en,
	input  wire [3:0]       byte_en,
	input  wire [31:0]      write_data,
	// stored value
	output reg  [WIDTH-1:0] value
);
	wire [WIDTH-1:0] next_value;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : bit_cell
			// one process owns the whole word; lanes only pick the next value per bit
			assign next_value[i] = (write_en && byte_en[i / 8]) ? write_data[i] : value[i];
		end
	endgenerate

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			value <= {WIDTH{1'b0}}; // RQ6
		else
			value <= next_value;
	end
endmodule

// ===== src/fir_equalizer_coef_bank.v
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fir_equalizer_coef_regs.vh"
// Summary of operation
// RQ1 - low twelve bits of each outer coefficient are a signed tap weight
// RQ2 - first-bank registers feed taps six to nine of channel a in dual mode
// RQ3 - in single mode the same registers feed the only filter's taps
// RQ4 - second-bank first register is channel b first tap, dual mode only
// RQ5 - next second-bank register is channel b second tap, dual mode only
// RQ6 - every coefficient register reads zero after reset
// RQ7 - the centre tap carries an eighteen-bit signed coefficient
// RQ8 - software writes zero to reserved bits; taps ignore them
module fir_equalizer_coef_bank
(
	// clock and reset
	input  wire               CLOCK,
	input  wire               RESET_N,
	// axi4-lite write address
	input  wire [31:0]        S_AXI_AWADDR,
	input  wire               S_AXI_AWVALID,
	output reg                S_AXI_AWREADY,
	// axi4-lite write data
	input  wire [31:0]        S_AXI_WDATA,
	input  wire [3:0]         S_AXI_WSTRB,
	input  wire               S_AXI_WVALID,
	output reg                S_AXI_WREADY,
	// axi4-lite write response
	output reg  [1:0]         S_AXI_BRESP,
	output reg                S_AXI_BVALID,
	input  wire               S_AXI_BREADY,
	// axi4-lite read address
	input  wire [31:0]        S_AXI_ARADDR,
	input  wire               S_AXI_ARVALID,
	output reg                S_AXI_ARREADY,
	// axi4-lite read data
	output reg  [31:0]        S_AXI_RDATA,
	output reg  [1:0]         S_AXI_RRESP,
	output reg                S_AXI_RVALID,
	input  wire               S_AXI_RREADY,
	// tap weights, filter a (dual) or the single filter
	output reg  [11:0]        TAP_A6,
	output reg  [11:0]        TAP_A7,
	output reg  [11:0]        TAP_A8,
	output reg  [11:0]        TAP_A9,
	output reg  [17:0]        TAP_A_CENTER,
	// tap weights, filter b
	output reg  [11:0]        TAP_B1,
	output reg  [11:0]        TAP_B2,
	// mode state
	output reg                DUAL_MODE
);
	localparam NREG = 8;
	localparam R_A6 = 0;
	localparam R_A7 = 1;
	localparam R_A8 = 2;
	localparam R_A9 = 3;
	localparam R_B1 = 4;
	localparam R_B2 = 5;
	localparam R_AC = 6;
	localparam R_MD = 7;

	// one-hot write states
	localparam W_IDLE = 3'b001;
	localparam W_RESP = 3'b010;
	localparam W_HOLD = 3'b100;

	reg  [2:0]        wstate;
	reg  [31:0]       awaddr;
	reg               aw_held;
	reg  [31:0]       wdata;
	reg  [3:0]        wstrb;
	reg               w_held;
	reg               mode_dual;
	wire [15:0]       raw_a6;
	wire [15:0]       raw_a7;
	wire [15:0]       raw_a8;
	wire [15:0]       raw_a9;
	wire [15:0]       raw_b1;
	wire [15:0]       raw_b2;
	wire [23:0]       raw_ac;
	wire [11:0]       sel_b1;
	wire [11:0]       sel_b2;
	wire [NREG-1:0]   wsel;
	wire [NREG-1:0]   wr_en;
	wire              do_write;
	wire              aw_now;
	wire              w_now;
	wire [31:0]       eff_awaddr;
	wire [31:0]       eff_wdata;
	wire [3:0]        eff_wstrb;

	// register decode shared by both channels; upper address bits must match too
	function [NREG-1:0] decode;
		input [31:0] addr;
		begin
			decode = {NREG{1'b0}};
			if (addr[1:0] == 2'h0 && addr[31:14] == 18'h00000)
			begin
				case (addr[13:2])
					`IDX_COEF_A_TAP6:       decode[R_A6] = 1'b1;
					`IDX_COEF_A_TAP7:       decode[R_A7] = 1'b1;
					`IDX_COEF_A_TAP8:       decode[R_A8] = 1'b1;
					`IDX_COEF_A_TAP9:       decode[R_A9] = 1'b1;
					`IDX_COEF_B_TAP1:       decode[R_B1] = 1'b1;
					`IDX_COEF_B_TAP2:       decode[R_B2] = 1'b1;
					`IDX_COEF_A_CENTER_TAP: decode[R_AC] = 1'b1;
					`IDX_MODE_CTRL:         decode[R_MD] = 1'b1;
					default:                decode = {NREG{1'b0}};
				endcase
			end
		end
	endfunction

	// address and data may arrive in either order; each is held until both are in
	assign aw_now     = S_AXI_AWVALID && S_AXI_AWREADY;
	assign w_now      = S_AXI_WVALID && S_AXI_WREADY;
	assign eff_awaddr = aw_held ? awaddr : S_AXI_AWADDR;
	assign eff_wdata  = w_held ? wdata : S_AXI_WDATA;
	assign eff_wstrb  = w_held ? wstrb : S_AXI_WSTRB;
	assign do_write   = (wstate == W_IDLE) && (aw_held || aw_now) && (w_held || w_now);
	assign wsel       = decode(eff_awaddr);
	assign wr_en      = do_write ? wsel : {NREG{1'b0}};

	coef_reg #(.WIDTH(16)) u_a6
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_A6]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_a6)
	);
	coef_reg #(.WIDTH(16)) u_a7
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_A7]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_a7)
	);
	coef_reg #(.WIDTH(16)) u_a8
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_A8]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_a8)
	);
	coef_reg #(.WIDTH(16)) u_a9
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_A9]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_a9)
	);
	coef_reg #(.WIDTH(16)) u_b1
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_B1]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_b1)
	);
	coef_reg #(.WIDTH(16)) u_b2
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_B2]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_b2)
	);
	// centre tap is wider: eighteen-bit field in a 24-bit register
	coef_reg #(.WIDTH(24)) u_ac
	(
		.clock      (CLOCK),
		.reset_n    (RESET_N),
		.write_en   (wr_en[R_AC]),
		.byte_en    (eff_wstrb),
		.write_data (eff_wdata),
		.value      (raw_ac)
	); // RQ7

	tap_select u_sel
	(
		.dual_mode  (mode_dual),
		.raw_b_tap1 (raw_b1),
		.raw_b_tap2 (raw_b2),
		.tap_b1     (sel_b1),
		.tap_b2     (sel_b2)
	);

	// mode control register
	always @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			mode_dual <= `MODE_RESET;
		else if (wr_en[R_MD] && eff_wstrb[0])
			mode_dual <= eff_wdata[`MODE_DUAL_BIT];
	end

	// write channel
	always @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			wstate        <= W_IDLE;
			awaddr        <= 32'h00000000;
			aw_held       <= 1'b0;
			wdata         <= 32'h00000000;
			wstrb         <= 4'h0;
			w_held        <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= `RESP_OKAY;
		end
		else
		begin
			case (wstate)
				W_IDLE:
				begin
					if (aw_now)
					begin
						awaddr  <= S_AXI_AWADDR;
						aw_held <= 1'b1;
					end
					if (w_now)
					begin
						wdata  <= S_AXI_WDATA;
						wstrb  <= S_AXI_WSTRB;
						w_held <= 1'b1;
					end
					if (do_write)
					begin
						S_AXI_AWREADY <= 1'b0;
						S_AXI_WREADY  <= 1'b0;
						S_AXI_BVALID  <= 1'b1;
						S_AXI_BRESP   <= (wsel == {NREG{1'b0}}) ? `RESP_SLVERR : `RESP_OKAY;
						aw_held       <= 1'b0;
						w_held        <= 1'b0;
						wstate        <= W_RESP;
					end
					else
					begin
						S_AXI_AWREADY <= !(aw_held || aw_now);
						S_AXI_WREADY  <= !(w_held || w_now);
					end
				end
				W_RESP:
				begin
					if (S_AXI_BREADY)
					begin
						S_AXI_BVALID <= 1'b0;
						wstate       <= W_HOLD;
					end
				end
				W_HOLD:
				begin
					S_AXI_AWREADY <= 1'b1;
					S_AXI_WREADY  <= 1'b1;
					wstate        <= W_IDLE;
				end
				default:
					wstate <= W_IDLE;
			endcase
		end
	end

	// read channel; unmapped addresses read zero with slverr
	always @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h00000000;
			S_AXI_RRESP   <= `RESP_OKAY;
		end
		else if (S_AXI_RVALID)
		begin
			if (S_AXI_RREADY)
			begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b1;
			S_AXI_RRESP   <= `RESP_OKAY;
			case (decode(S_AXI_ARADDR))
				8'h01:   S_AXI_RDATA <= {16'h0000, raw_a6};
				8'h02:   S_AXI_RDATA <= {16'h0000, raw_a7};
				8'h04:   S_AXI_RDATA <= {16'h0000, raw_a8};
				8'h08:   S_AXI_RDATA <= {16'h0000, raw_a9};
				8'h10:   S_AXI_RDATA <= {16'h0000, raw_b1};
				8'h20:   S_AXI_RDATA <= {16'h0000, raw_b2};
				8'h40:   S_AXI_RDATA <= {8'h00, raw_ac};
				8'h80:   S_AXI_RDATA <= {31'h00000000, mode_dual};
				default:
				begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= `RESP_SLVERR;
				end
			endcase
		end
		else
			S_AXI_ARREADY <= 1'b1;
	end

	// tap outputs drop reserved bits so stray writes there have no effect
	always @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			TAP_A6       <= 12'h000;
			TAP_A7       <= 12'h000;
			TAP_A8       <= 12'h000;
			TAP_A9       <= 12'h000;
			TAP_A_CENTER <= 18'h00000;
			TAP_B1       <= 12'h000;
			TAP_B2       <= 12'h000;
			DUAL_MODE    <= 1'b0;
		end
		else
		begin
			// same registers serve filter a or the single filter; mode does not gate them
			TAP_A6       <= raw_a6[`COEF_MSB:0]; // RQ1
			TAP_A7       <= raw_a7[`COEF_MSB:0]; // RQ2
			TAP_A8       <= raw_a8[`COEF_MSB:0]; // RQ3
			TAP_A9       <= raw_a9[`COEF_MSB:0]; // RQ8
			TAP_A_CENTER <= raw_ac[`CENTER_MSB:0]; // RQ7
			TAP_B1       <= sel_b1; // RQ4
			TAP_B2       <= sel_b2; // RQ5
			DUAL_MODE    <= mode_dual;
		end
	end
endmodule

// ===== src/fir_equalizer_coef_regs.vh
`ifndef FIR_EQUALIZER_COEF_REGS_VH
`define FIR_EQUALIZER_COEF_REGS_VH

// register indices as printed; byte address is four times the index
`define IDX_COEF_A_TAP6        12'h423
`define IDX_COEF_A_TAP7        12'h425
`define IDX_COEF_A_TAP8        12'h427
`define IDX_COEF_A_TAP9        12'h429
`define IDX_COEF_B_TAP1        12'h448
`define IDX_COEF_B_TAP2        12'h44A
`define IDX_COEF_A_CENTER_TAP  12'h420
`define IDX_MODE_CTRL          12'h470

// field layout
`define COEF_MSB               11
`define COEF_REG_MSB           15
`define CENTER_MSB             17
`define CENTER_REG_MSB         23
`define MODE_DUAL_BIT          0

// reset values
`define COEF_RESET             16'h0000
`define CENTER_RESET           24'h000000
`define MODE_RESET             1'h0

// bus answers
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// ===== src/tap_select.v
`timescale 1ns/10ps
`include "fir_equalizer_coef_regs.vh"
module tap_select
(
	// mode and stored registers
	input  wire        dual_mode,
	input  wire [15:0] raw_b_tap1,
	input  wire [15:0] raw_b_tap2,
	// tap weights for the channel b filter
	output wire [11:0] tap_b1,
	output wire [11:0] tap_b2
);
	// channel b taps are zero weight outside dual-channel mode
	assign tap_b1 = dual_mode ? raw_b_tap1[`COEF_MSB:0] : 12'h000; // RQ4
	assign tap_b2 = dual_mode ? raw_b_tap2[`COEF_MSB:0] : 12'h000; // RQ5
endmodule

// ===== tb/fir_equalizer_coef_bank_properties.sv
`timescale 1ns/10ps
module fir_equalizer_coef_bank_properties
(
	// clock and reset
	input wire        CLOCK, RESET_N,
	// bus handshakes
	input wire        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
	input wire        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY,
	input wire        S_AXI_RVALID, S_AXI_RREADY,
	input wire [1:0]  S_AXI_BRESP, S_AXI_RRESP,
	input wire [31:0] S_AXI_RDATA,
	// taps and mode
	input wire [11:0] TAP_A6, TAP_A7, TAP_A8, TAP_A9, TAP_B1, TAP_B2,
	input wire [17:0] TAP_A_CENTER,
	input wire        DUAL_MODE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	// three cycles covers the one-cycle lag of the mode copy and the tap copy
	chk_b1_single: assert property (
		!DUAL_MODE [*3] |-> TAP_B1 == 12'h000) else $error("tap b1 live in single mode");
	chk_b2_single: assert property (
		!DUAL_MODE [*3] |-> TAP_B2 == 12'h000) else $error("tap b2 live in single mode");
	chk_reset_taps: assert property (
		$rose(RESET_N) |-> {TAP_A6, TAP_A7, TAP_A8, TAP_A9, TAP_B1, TAP_B2, TAP_A_CENTER} == 90'h0)
		else $error("taps not zero after reset");
	chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |=> S_AXI_BVALID) else $error("write answer late");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
		&& $stable(S_AXI_BRESP)) else $error("write answer dropped");
	chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
		&& $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP)) else $error("read answer dropped");
	chk_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read address taken while answer pending");
	chk_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:24] == 8'h00)
		else $error("unused read bits set");
endmodule
bind fir_equalizer_coef_bank fir_equalizer_coef_bank_properties chk (.*);

// ===== tb/fir_equalizer_coef_bank_tb_top.sv
`timescale 1ns/10ps
`include "fir_equalizer_coef_regs.vh"
module fir_equalizer_coef_bank_tb_top;
	reg         CLOCK = 1'h0, RESET_N = 1'h0;
	reg  [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
	reg  [3:0]  S_AXI_WSTRB = 4'h0;
	reg         S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	reg         S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	wire        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	wire        DUAL_MODE;
	wire [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	wire [31:0] S_AXI_RDATA;
	wire [11:0] TAP_A6, TAP_A7, TAP_A8, TAP_A9, TAP_B1, TAP_B2;
	wire [17:0] TAP_A_CENTER;
	integer     num_errors = 0, n_checks = 0, i;
	reg  [11:0] idx [0:5];
	reg  [31:0] rd;
	reg  [1:0]  rs;

	fir_equalizer_coef_bank DUT (.*);
	always #4 CLOCK = ~CLOCK;

	function [31:0] ba(input [11:0] x);
		ba = {18'h0, x, 2'h0};
	endfunction
	// reserved nibble set on purpose in every value, sign bit in the last three
	function [31:0] v(input integer k);
		v = 32'hFFFFF000 | ((k + 1) * 32'h211);
	endfunction
	function [11:0] tap_of(input integer k);
		case (k)
			0: tap_of = TAP_A6;
			1: tap_of = TAP_A7;
			2: tap_of = TAP_A8;
			3: tap_of = TAP_A9;
			4: tap_of = TAP_B1;
			default: tap_of = TAP_B2;
		endcase
	endfunction

	task end_of_test;
	begin
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task check(input [63:0] what, input [31:0] seen, input [31:0] exp);
	begin
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("BAD %0s exp %h seen %h", what, exp, seen);
		end
	end
	endtask
	task hung;
	begin
		num_errors = num_errors + 1;
		$display("BAD bus wait ran out");
		end_of_test;
	end
	endtask
	task wr(input [31:0] a, input [31:0] d, input [3:0] s);
		integer n;
		reg aw, w, done;
	begin
		@(posedge CLOCK);
		S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'h1; S_AXI_WVALID <= 1'h1; S_AXI_BREADY <= 1'h1;
		aw = 1; w = 1; done = 0;
		for (n = 0; n < 100 && !done; n = n + 1)
		begin
			@(posedge CLOCK);
			if (aw && S_AXI_AWREADY)
			begin
				S_AXI_AWVALID <= 1'h0; aw = 0;
			end
			if (w && S_AXI_WREADY)
			begin
				S_AXI_WVALID <= 1'h0; w = 0;
			end
			if (S_AXI_BVALID)
			begin
				rs = S_AXI_BRESP; S_AXI_BREADY <= 1'h0; done = 1;
			end
		end
		if (!done) hung;
	end
	endtask
	task rdr(input [31:0] a);
		integer n;
		reg ar, done;
	begin
		@(posedge CLOCK);
		S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1'h1; S_AXI_RREADY <= 1'h1;
		ar = 1; done = 0;
		for (n = 0; n < 100 && !done; n = n + 1)
		begin
			@(posedge CLOCK);
			if (ar && S_AXI_ARREADY)
			begin
				S_AXI_ARVALID <= 1'h0; ar = 0;
			end
			if (S_AXI_RVALID)
			begin
				rd = S_AXI_RDATA; rs = S_AXI_RRESP; S_AXI_RREADY <= 1'h0; done = 1;
			end
		end
		if (!done) hung;
	end
	endtask
	task set_mode(input [31:0] m);
	begin
		wr(ba(`IDX_MODE_CTRL), m, 4'hF);
		repeat (3) @(posedge CLOCK);
		check("mode", DUAL_MODE, m[0]);
	end
	endtask

	task t_reset;
	begin
		for (i = 0; i < 6; i = i + 1)
		begin
			rdr(ba(idx[i]));
			check("rst rd", rd, 32'h0);
			check("rst rsp", rs, `RESP_OKAY);
			check("rst tap", tap_of(i), 32'h0);
		end
		rdr(ba(`IDX_COEF_A_CENTER_TAP));
		check("rst ctr", rd, 32'h0);
	end
	endtask
	task t_dual;
	begin
		set_mode(32'h1);
		for (i = 0; i < 6; i = i + 1)
			wr(ba(idx[i]), v(i), 4'hF);
		repeat (3) @(posedge CLOCK);
		for (i = 0; i < 6; i = i + 1)
		begin
			check("tap", tap_of(i), v(i) & 32'hFFF);
			rdr(ba(idx[i]));
			check("rdback", rd, v(i) & 32'hFFFF);
		end
	end
	endtask
	task t_single;
	begin
		set_mode(32'h0);
		for (i = 0; i < 6; i = i + 1)
			check("single", tap_of(i), i < 4 ? v(i) & 32'hFFF : 32'h0);
		wr(ba(`IDX_COEF_A_TAP9), 32'h0000A7FF, 4'hF);
		repeat (3) @(posedge CLOCK);
		check("s tap9", TAP_A9, 32'h7FF);
		set_mode(32'h1);
		check("b1 back", TAP_B1, v(4) & 32'hFFF);
	end
	endtask
	task t_center_strobe;
	begin
		wr(ba(`IDX_COEF_A_CENTER_TAP), 32'hFFFFFFFF, 4'hF);
		rdr(ba(`IDX_COEF_A_CENTER_TAP));
		check("ctr rd", rd, 32'h00FFFFFF);
		check("ctr tap", TAP_A_CENTER, 32'h3FFFF);
		wr(ba(`IDX_COEF_A_TAP7), 32'h0, 4'h2);
		rdr(ba(`IDX_COEF_A_TAP7));
		check("strobe", rd, v(1) & 32'hFF);
		check("str tap", TAP_A7, v(1) & 32'hFF);
	end
	endtask
	task t_reset_mid;
	begin
		@(posedge CLOCK);
		RESET_N <= 1'h0;
		repeat (2) @(posedge CLOCK);
		check("mid ctr", TAP_A_CENTER, 32'h0);
		check("mid a7", TAP_A7, 32'h0);
		check("mid mode", DUAL_MODE, 32'h0);
		RESET_N <= 1'h1;
		t_reset;
	end
	endtask
	task t_unmapped;
	begin
		wr(32'h00002000, 32'h1, 4'hF);
		check("bad wr", rs, `RESP_SLVERR);
		rdr(ba(`IDX_COEF_B_TAP2) + 32'h1);
		check("bad rd", rd, 32'h0);
		check("bad rsp", rs, `RESP_SLVERR);
	end
	endtask

	initial
	begin
		idx[0] = `IDX_COEF_A_TAP6; idx[1] = `IDX_COEF_A_TAP7; idx[2] = `IDX_COEF_A_TAP8;
		idx[3] = `IDX_COEF_A_TAP9; idx[4] = `IDX_COEF_B_TAP1; idx[5] = `IDX_COEF_B_TAP2;
		repeat (4) @(posedge CLOCK);
		RESET_N <= 1'h1;
		t_reset;
		t_dual;
		t_single;
		t_center_strobe;
		t_reset_mid;
		t_unmapped;
		end_of_test;
	end
endmodule
